//--- logic/mscg_consts.svh
/*
 * Constants of the marker and symbol clock generator: register offsets,
 * field positions, reset values and timing figures.
 * Assumes inclusion by the package, the top module, the checker and the bench.
 */
`ifndef MSCG_CONSTS_SVH
`define MSCG_CONSTS_SVH

`define MSCG_NMARK 2
`define MSCG_A_CTRL 8'h00
`define MSCG_A_SYMDIV 8'h04
`define MSCG_A_MULT 8'h08
`define MSCG_A_BITS 8'h0C
`define MSCG_A_FREQ 8'h10
`define MSCG_A_DMIN 8'h14
`define MSCG_A_DMAX 8'h18
`define MSCG_MK0_PAGE 3'h1
`define MSCG_MK1_PAGE 3'h2
`define MSCG_F_MODE 3'h0
`define MSCG_F_PDIV 3'h1
`define MSCG_F_PATLO 3'h2
`define MSCG_F_PATHI 3'h3
`define MSCG_F_PLEN 3'h4
`define MSCG_F_ON 3'h5
`define MSCG_F_OFF 3'h6
`define MSCG_F_DLY 3'h7
`define MSCG_C_EXT 0
`define MSCG_C_MODE_LO 1
`define MSCG_C_MODE_HI 2
`define MSCG_C_POL 3
`define MSCG_C_FIX 4
`define MSCG_DLY_MIN 16'h0000
`define MSCG_DLY_MAX 16'h003F
`define MSCG_HIST 63
`define MSCG_SYMDIV_RST 16'h0004
`define MSCG_MULT_RST 16'h0002
`define MSCG_BITS_RST 16'h0002
`define MSCG_PDIV_RST 16'h0002
`define MSCG_ONOFF_RST 16'h0001
`define MSCG_PLEN_MAX 7'h40
`define MSCG_PCLK_KHZ 50000
`define MSCG_GATE_US 1000

`endif

//--- logic/mscg_pkg.sv
/*
 * Types of the marker and symbol clock generator.
 * Assumes the constants header sits beside it.
 */
`include "mscg_consts.svh"

package mscg_pkg;

   typedef enum logic [1:0] {MSCG_LIST, MSCG_PULSE, MSCG_PATTERN, MSCG_ONOFF} mscg_mk_mode_t;

   typedef enum logic [1:0] {MSCG_CK_SYM, MSCG_CK_MULTI, MSCG_CK_BIT} mscg_ck_mode_t;

   typedef struct packed
   {
      mscg_mk_mode_t mode;
      logic [15:0] pdiv;
      logic [63:0] pattern;
      logic [6:0] plen;
      logic [15:0] on_t;
      logic [15:0] off_t;
      logic [15:0] delay;
   } mscg_mkcfg_t;

   typedef struct packed
   {
      logic ext;
      mscg_ck_mode_t mode;
      logic pol;
      logic fix;
      logic [15:0] symdiv;
      logic [15:0] mult;
      logic [15:0] bits;
   } mscg_ckcfg_t;

endpackage

//--- logic/mscg_top.sv
/*
 * Marker generator and symbol clock source selection, APB slave.
 * Assumes a 50 MHz pclk, an external clock pin slower than pclk/4,
 * and control list marker bits from logic on pclk.
 */
// Summary of operation
// (R1) Pulse mode: marker frequency is sample rate divided by programmable divider.
// (R2) List-driven mode: marker follows control list marker bit.
// (R3) Pattern mode: marker from programmable pattern up to 64 bits.
// (R4) One pattern bit per symbol, wrapping after last bit, repeating.
// (R5) On/off mode: period is one active then one inactive interval.
// (R6) Separate active and inactive counts, in whole symbols.
// (R7) Per-marker delay in symbols from signal start to marker.
// (R8) Minimum and maximum no-restart delay are readable.
// (R9) Delay-fix option clamps delay to no-restart range; changes apply live.
// (R10) Delay change outside that range restarts marker and signal generation.
// (R11) Internal source: symbol timing from internal clock, external pin ignored.
// (R12) External source: symbol timing from clock pin, symbol rate or multiple.
// (R13) Supplied external clock must match programmed rate within two percent.
// (R14) External clock polarity is selectable.
// (R15) Symbol clock mode: each active edge is one symbol.
// (R16) Multiple mode: external clock divided by the multiplier.
// (R17) Bit mode: external bit clock divided into symbol clock.
// (R18) Multiple and bit modes refused while external data source selected.
// (R19) External clock frequency measured continuously while external selected.
`include "mscg_consts.svh"

module mscg_top
   import mscg_pkg::*;
#(
   parameter int unsigned GATE_CYC = `MSCG_GATE_US * (`MSCG_PCLK_KHZ / 1000)
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_in,
   input wire logic ext_data_sel,
   input wire logic [1:0] list_marker,
   output logic [1:0] marker_out,
   output logic sym_tick,
   output logic gen_restart
);

   localparam int NM = `MSCG_NMARK;

   function automatic logic [16:0] wrap_next(input logic [16:0] cnt, input logic [16:0] lim);
      if (cnt + 17'h00001 >= lim)
         wrap_next = 17'h00000;
      else
         wrap_next = cnt + 17'h00001;
   endfunction

   function automatic logic [16:0] lim_of(input logic [15:0] v);
      lim_of = (v == 16'h0000) ? 17'h00001 : {1'b0, v};
   endfunction

   function automatic logic [15:0] coarse_of(input logic [15:0] d);
      coarse_of = (d > `MSCG_DLY_MAX) ? d - `MSCG_DLY_MAX : 16'h0000;
   endfunction

   mscg_ckcfg_t ck;
   mscg_mkcfg_t mk [NM];
   logic [2:0] ext_sync;
   logic ext_lvl;
   logic ext_lvl_d;
   logic [16:0] int_cnt;
   logic [16:0] ext_cnt;
   logic [31:0] gate_cnt;
   logic [31:0] edge_cnt;
   logic [31:0] freq_cnt;
   logic [16:0] mcnt [NM];
   logic [15:0] hold [NM];
   logic [`MSCG_HIST-1:0] hist [NM];

   // APB decode.
   wire setup_ph = psel & ~penable;
   wire acc_ph = psel & penable;
   wire wr_en = acc_ph & pwrite;
   wire word_ok = (paddr[1:0] == 2'b00);
   wire [2:0] page = paddr[7:5];
   wire [2:0] fld = paddr[4:2];
   wire mk_hit = word_ok & ((page == `MSCG_MK0_PAGE) | (page == `MSCG_MK1_PAGE));
   wire mk_idx = (page == `MSCG_MK1_PAGE);
   wire wr_mk = wr_en & mk_hit;
   wire wr_ctrl = wr_en & (paddr == `MSCG_A_CTRL);
   wire wr_symdiv = wr_en & (paddr == `MSCG_A_SYMDIV);
   wire wr_mult = wr_en & (paddr == `MSCG_A_MULT);
   wire wr_bits = wr_en & (paddr == `MSCG_A_BITS);
   wire wr_dly = wr_mk & (fld == `MSCG_F_DLY);

   // Delay write: clamp when fixed, restart when the value changes and the old or new value lies outside the live range.
   wire [15:0] dly_raw = pwdata[15:0];
   wire [15:0] dly_clamp = (dly_raw > `MSCG_DLY_MAX) ? `MSCG_DLY_MAX :
                           (dly_raw < `MSCG_DLY_MIN) ? `MSCG_DLY_MIN : dly_raw; // R9
   wire [15:0] dly_new = ck.fix ? dly_clamp : dly_raw; // R9
   wire [15:0] dly_old = mk[mk_idx].delay;
   wire dly_out = (dly_new > `MSCG_DLY_MAX) | (dly_old > `MSCG_DLY_MAX);
   wire restart_req = wr_dly & dly_out & (dly_new != dly_old); // R10

   // A mode that needs clock division is refused while external data is in use.
   wire [1:0] mode_req = pwdata[`MSCG_C_MODE_HI:`MSCG_C_MODE_LO];
   wire mode_ok = ~ext_data_sel & ((mode_req == 2'd1) | (mode_req == 2'd2)); // R18
   wire [1:0] mode_sel = mode_ok ? mode_req : 2'd0; // R18
   wire ck_eff_sym = ext_data_sel | (ck.mode == MSCG_CK_SYM); // R18

   // Symbol clock generation.
   wire ext_edge = ck.pol ? (ext_lvl_d & ~ext_lvl) : (~ext_lvl_d & ext_lvl); // R14
   wire [16:0] ext_lim = ck_eff_sym ? 17'h00001 :
                         (ck.mode == MSCG_CK_MULTI) ? lim_of(ck.mult) : // R16
                         lim_of(ck.bits); // R17
   wire [16:0] ext_next = wrap_next(ext_cnt, ext_lim);
   wire [16:0] int_next = wrap_next(int_cnt, lim_of(ck.symdiv));
   wire ext_tick = ext_edge & (ext_next == 17'h00000); // R15
   wire int_tick = (int_next == 17'h00000);
   wire next_tick = ck.ext ? ext_tick : int_tick; // R11 R12

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ck.ext <= 1'b0;
         ck.mode <= MSCG_CK_SYM;
         ck.pol <= 1'b0;
         ck.fix <= 1'b0;
         ck.symdiv <= `MSCG_SYMDIV_RST;
         ck.mult <= `MSCG_MULT_RST;
         ck.bits <= `MSCG_BITS_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ck.ext <= pwdata[`MSCG_C_EXT];
            ck.mode <= mscg_ck_mode_t'(mode_sel);
            ck.pol <= pwdata[`MSCG_C_POL];
            ck.fix <= pwdata[`MSCG_C_FIX];
         end
         if (wr_symdiv)
            ck.symdiv <= pwdata[15:0];
         if (wr_mult)
            ck.mult <= pwdata[15:0];
         if (wr_bits)
            ck.bits <= pwdata[15:0];
      end
   end

   // Marker configuration registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int m = 0; m < NM; m++)
         begin
            mk[m].mode <= MSCG_PULSE;
            mk[m].pdiv <= `MSCG_PDIV_RST;
            mk[m].pattern <= 64'h0000_0000_0000_0000;
            mk[m].plen <= `MSCG_PLEN_MAX;
            mk[m].on_t <= `MSCG_ONOFF_RST;
            mk[m].off_t <= `MSCG_ONOFF_RST;
            mk[m].delay <= `MSCG_DLY_MIN;
         end
      end
      else if (wr_mk)
      begin
         if (fld == `MSCG_F_MODE)
            mk[mk_idx].mode <= mscg_mk_mode_t'(pwdata[1:0]);
         else if (fld == `MSCG_F_PDIV)
            mk[mk_idx].pdiv <= pwdata[15:0];
         else if (fld == `MSCG_F_PATLO)
            mk[mk_idx].pattern[31:0] <= pwdata;
         else if (fld == `MSCG_F_PATHI)
            mk[mk_idx].pattern[63:32] <= pwdata;
         else if (fld == `MSCG_F_PLEN)
            mk[mk_idx].plen <= (pwdata > {25'h0000000, `MSCG_PLEN_MAX}) ?
                               `MSCG_PLEN_MAX : pwdata[6:0]; // R3
         else if (fld == `MSCG_F_ON)
            mk[mk_idx].on_t <= pwdata[15:0]; // R6
         else if (fld == `MSCG_F_OFF)
            mk[mk_idx].off_t <= pwdata[15:0]; // R6
         else
            mk[mk_idx].delay <= dly_new; // R7
      end
   end

   // External pin: three stages, a change is taken once stages two and three agree.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_sync <= 3'b000;
         ext_lvl <= 1'b0;
         ext_lvl_d <= 1'b0;
      end
      else
      begin
         ext_sync <= {ext_sync[1:0], ext_clk_in};
         if (ext_sync[2] == ext_sync[1])
            ext_lvl <= ext_sync[2];
         ext_lvl_d <= ext_lvl;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_cnt <= 17'h00000;
         ext_cnt <= 17'h00000;
         sym_tick <= 1'b0;
      end
      else
      begin
         int_cnt <= ck.ext ? 17'h00000 : int_next;
         if (!ck.ext)
            ext_cnt <= 17'h00000; // R11
         else if (ext_edge)
            ext_cnt <= ext_next;
         sym_tick <= next_tick;
      end
   end

   // Frequency: active edges counted over a fixed gate while external is selected.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gate_cnt <= 32'h0000_0000;
         edge_cnt <= 32'h0000_0000;
         freq_cnt <= 32'h0000_0000;
      end
      else if (!ck.ext)
      begin
         gate_cnt <= 32'h0000_0000;
         edge_cnt <= 32'h0000_0000;
         freq_cnt <= 32'h0000_0000;
      end
      else if (gate_cnt >= GATE_CYC - 1)
      begin
         gate_cnt <= 32'h0000_0000;
         edge_cnt <= 32'h0000_0000;
         freq_cnt <= edge_cnt + {31'h0000_0000, ext_edge}; // R19
      end
      else
      begin
         gate_cnt <= gate_cnt + 32'h0000_0001;
         edge_cnt <= edge_cnt + {31'h0000_0000, ext_edge}; // R19
      end
   end

   // Marker sources per marker.
   logic [16:0] mlim [NM];
   logic mraw [NM];
   logic mdel [NM];
   logic [15:0] tap [NM];

   always_comb
   begin
      for (int m = 0; m < NM; m++)
      begin
         tap[m] = (mk[m].delay > `MSCG_DLY_MAX) ? `MSCG_DLY_MAX : mk[m].delay;
         case (mk[m].mode)
            MSCG_PULSE:
            begin
               mlim[m] = lim_of(mk[m].pdiv);
               mraw[m] = (mcnt[m] < ((mlim[m] + 17'h00001) >> 1)); // R1
            end
            MSCG_PATTERN:
            begin
               mlim[m] = lim_of({9'h000, mk[m].plen});
               mraw[m] = mk[m].pattern[mcnt[m][5:0]]; // R3
            end
            MSCG_ONOFF:
            begin
               mlim[m] = {1'b0, mk[m].on_t} + {1'b0, mk[m].off_t};
               mraw[m] = (mcnt[m] < {1'b0, mk[m].on_t}); // R5
            end
            default:
            begin
               mlim[m] = 17'h00001;
               mraw[m] = list_marker[m]; // R2
            end
         endcase
         mdel[m] = (tap[m] == 16'h0000) ? mraw[m] : hist[m][tap[m][5:0] - 6'h01]; // R7
      end
   end

   // A restart clears every marker source and replays the part of the delay
   // that the history cannot hold as a hold-off in symbols.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gen_restart <= 1'b0;
         marker_out <= 2'b00;
         for (int m = 0; m < NM; m++)
         begin
            mcnt[m] <= 17'h00000;
            hold[m] <= 16'h0000;
            hist[m] <= '0;
         end
      end
      else
      begin
         gen_restart <= restart_req; // R10
         for (int m = 0; m < NM; m++)
         begin
            if (gen_restart)
            begin
               mcnt[m] <= 17'h00000; // R10
               hist[m] <= '0;
               hold[m] <= coarse_of(mk[m].delay); // R7
            end
            else if (sym_tick)
            begin
               if (hold[m] != 16'h0000)
                  hold[m] <= hold[m] - 16'h0001;
               else
               begin
                  mcnt[m] <= wrap_next(mcnt[m], mlim[m]); // R4 R6
                  hist[m] <= {hist[m][`MSCG_HIST-2:0], mraw[m]};
               end
            end
            marker_out[m] <= (hold[m] == 16'h0000) & mdel[m];
         end
      end
   end

   // Read path, captured in the setup phase so prdata comes from a flip-flop.
   logic [31:0] rd_val;
   logic rd_hit;

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == `MSCG_A_CTRL)
         rd_val = {27'h0, ck.fix, ck.pol, ck.mode, ck.ext};
      else if (paddr == `MSCG_A_SYMDIV)
         rd_val = {16'h0000, ck.symdiv};
      else if (paddr == `MSCG_A_MULT)
         rd_val = {16'h0000, ck.mult};
      else if (paddr == `MSCG_A_BITS)
         rd_val = {16'h0000, ck.bits};
      else if (paddr == `MSCG_A_FREQ)
         rd_val = freq_cnt; // R19
      else if (paddr == `MSCG_A_DMIN)
         rd_val = {16'h0000, `MSCG_DLY_MIN}; // R8
      else if (paddr == `MSCG_A_DMAX)
         rd_val = {16'h0000, `MSCG_DLY_MAX}; // R8
      else if (mk_hit && fld == `MSCG_F_MODE)
         rd_val = {30'h0, mk[mk_idx].mode};
      else if (mk_hit && fld == `MSCG_F_PDIV)
         rd_val = {16'h0000, mk[mk_idx].pdiv};
      else if (mk_hit && fld == `MSCG_F_PATLO)
         rd_val = mk[mk_idx].pattern[31:0];
      else if (mk_hit && fld == `MSCG_F_PATHI)
         rd_val = mk[mk_idx].pattern[63:32];
      else if (mk_hit && fld == `MSCG_F_PLEN)
         rd_val = {25'h0, mk[mk_idx].plen};
      else if (mk_hit && fld == `MSCG_F_ON)
         rd_val = {16'h0000, mk[mk_idx].on_t};
      else if (mk_hit && fld == `MSCG_F_OFF)
         rd_val = {16'h0000, mk[mk_idx].off_t};
      else if (mk_hit)
         rd_val = {16'h0000, mk[mk_idx].delay};
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr <= ~rd_hit;
      end
   end

   assign pready = acc_ph;

endmodule

//--- verif/mscg_ext_eq.sv
/*
 * Model of the external test equipment: drives the clock pin at a fixed rate.
 * Assumes the bench raises run once the block is out of reset.
 */
module mscg_ext_eq
(
   input wire logic run,
   input wire logic [31:0] half_ns,
   output logic ext_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   // The 7 ns offset keeps pin edges clear of pclk edges, so the sync delay never jitters.
   initial
   begin
      ext_clk = 1'b0;
      #7;
      forever
      begin
         if (run)
            #(half_ns) ext_clk = ~ext_clk;
         else
            #20;
      end
   end
endmodule

//--- verif/mscg_top_asserts.sv
/*
 * Port checker of the marker and symbol clock generator.
 * Assumes one pclk domain and a symbol divider of at least two.
 */
`include "mscg_consts.svh"
module mscg_top_asserts
#(
   parameter int unsigned GATE_CYC = 50000
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_clk_in,
   input wire logic ext_data_sel,
   input wire logic [1:0] list_marker,
   input wire logic [1:0] marker_out,
   input wire logic sym_tick,
   input wire logic gen_restart
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready;
      pready == (psel && penable);
   endproperty
   a_ready: assert property (p_ready)
      else $error("pready not tied to the access phase");
   property p_unal;
      psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
   endproperty
   a_unal: assert property (p_unal)
      else $error("unaligned access not refused");
   property p_dmax;
      psel && penable && !pwrite && paddr == `MSCG_A_DMAX |-> prdata == 32'h3F && !pslverr;
   endproperty
   a_dmax: assert property (p_dmax)
      else $error("wrong maximum delay read");
   property p_dmin;
      psel && penable && !pwrite && paddr == `MSCG_A_DMIN |-> prdata == 32'h0 && !pslverr;
   endproperty
   a_dmin: assert property (p_dmin)
      else $error("wrong minimum delay read");
   property p_wzero;
      psel && penable && pwrite |-> prdata == 32'h0;
   endproperty
   a_wzero: assert property (p_wzero)
      else $error("read data not zero on a write");
   property p_rcause;
      $rose(gen_restart) |-> $past(psel && penable && pwrite) && $past(paddr[4:0]) == 5'h1C;
   endproperty
   a_rcause: assert property (p_rcause)
      else $error("restart without a delay write");
   property p_rpulse;
      gen_restart |=> !gen_restart;
   endproperty
   a_rpulse: assert property (p_rpulse)
      else $error("restart pulse too long");
   property p_tick;
      sym_tick |=> !sym_tick;
   endproperty
   a_tick: assert property (p_tick)
      else $error("symbol tick too long");
   c_restart: cover property (gen_restart);
   c_tick: cover property (sym_tick ##1 !sym_tick);
   c_err: cover property (pslverr && pready);
endmodule

bind mscg_top mscg_top_asserts #(.GATE_CYC(GATE_CYC)) u_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_clk_in(ext_clk_in), .ext_data_sel(ext_data_sel), .list_marker(list_marker),
   .marker_out(marker_out), .sym_tick(sym_tick), .gen_restart(gen_restart)
);

//--- verif/marker_and_symbol_clock_gen_tb.sv
/*
 * Self-checking bench of the marker and symbol clock generator.
 * Assumes the checker is bound in and the clock peer model is compiled.
 */
`include "mscg_consts.svh"
module marker_and_symbol_clock_gen_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_data_sel = 1'b0;
   logic [1:0] list_marker = 2'h0;
   logic [31:0] prdata, rd;
   logic [1:0] marker_out;
   logic pready, pslverr, ext_clk_in, sym_tick, gen_restart;
   logic run = 1'b0;
   logic [31:0] rnd = 32'hC607;
   logic [33:0] ex;
   logic [33:0] expq[$];
   logic s0[32];
   logic s1[32];
   int errors = 0;
   int check_count = 0;
   int restarts = 0;
   int n;
   logic [7:0] ra[13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28,
      8'h30, 8'h34, 8'h38, 8'h3C};
   logic [31:0] rv[13] = '{0, 4, 2, 2, 0, 63, 1, 2, 0, 64, 1, 1, 0};
   always #10 pclk = ~pclk;
   mscg_top #(.GATE_CYC(64)) dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_in(ext_clk_in), .ext_data_sel(ext_data_sel), .list_marker(list_marker),
      .marker_out(marker_out), .sym_tick(sym_tick), .gen_restart(gen_restart)
   );
   mscg_ext_eq peer(.run(run), .half_ns(200), .ext_clk(ext_clk_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // A read's note is {compare, pslverr, prdata}; the monitor pops it at the access edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] e);
      if (!w)
         expq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge pclk)
   begin
      if (gen_restart)
         restarts++;
      if (psel && penable && pready && !pwrite && expq.size() > 0)
      begin
         ex = expq.pop_front();
         rd <= prdata;
         if (ex[33])
            chk({pslverr, prdata}, ex[32:0]);
      end
   end
   task automatic sample();
      for (int i = 0; i < 32; i++)
      begin
         @(posedge pclk iff sym_tick);
         s0[i] = marker_out[0];
         s1[i] = marker_out[1];
      end
   endtask
   // Two ticks are skipped so a mode change never shortens the measured period.
   task automatic tp(output int c);
      @(posedge pclk iff sym_tick);
      @(posedge pclk);
      @(posedge pclk iff sym_tick);
      @(posedge pclk);
      c = 1;
      while (!sym_tick)
      begin
         @(posedge pclk);
         c++;
      end
   endtask
   function automatic int per(input int p);
      int c = 0;
      for (int i = 8; i < 32 - p; i++)
         if (s0[i] !== s0[i + p])
            return -1;
      for (int i = 8; i < 8 + p; i++)
         c += s0[i];
      return c;
   endfunction
   function automatic int rot(input logic [7:0] pat);
      int ok;
      for (int r = 0; r < 8; r++)
      begin
         ok = 1;
         for (int i = 8; i < 32; i++)
            if (s0[i] !== pat[(i + r) % 8])
               ok = 0;
         if (ok)
            return 1;
      end
      return 0;
   endfunction
   function automatic int lag(input int d);
      int c = 0;
      for (int i = 8; i < 28; i++)
         c += (s1[i + d] !== s0[i]);
      return c;
   endfunction
   initial
   begin
      #1000000;
      errors++;
      $display("MISMATCH %0t: run did not finish", $time);
      conclude();
   end
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      run <= 1'b1;
      for (int i = 0; i < 13; i++)
         apb(0, ra[i], 0, {2'b10, rv[i]});
      apb(0, 8'h1C, 0, 34'h3_0000_0000);
      apb(0, 8'h02, 0, 34'h3_0000_0000);
      apb(1, `MSCG_A_SYMDIV, 32'h5, 0);
      tp(n);
      chk(n, 5);
      apb(0, `MSCG_A_FREQ, 0, {2'b10, 32'h0});
      apb(1, 8'h24, 32'h4, 0);
      sample();
      chk(per(4), 2);
      apb(1, 8'h34, 32'h3, 0);
      apb(1, 8'h38, 32'h2, 0);
      apb(1, 8'h20, 32'h3, 0);
      sample();
      chk(per(5), 3);
      rnd = lfsr(rnd);
      for (int m = 0; m < 2; m++)
      begin
         apb(1, 8'h28 + 8'(m * 32), {24'h0, rnd[7:0]}, 0);
         apb(1, 8'h30 + 8'(m * 32), 32'h8, 0);
         apb(1, 8'h20 + 8'(m * 32), 32'h2, 0);
      end
      // Leaving the live range and coming back restarts both markers, so their counters align.
      apb(1, 8'h5C, 32'd100, 0);
      apb(1, 8'h5C, 32'h3, 0);
      sample();
      chk(rot(rnd[7:0]), 1);
      chk(lag(3), 0);
      apb(1, 8'h20, 32'h0, 0);
      apb(1, 8'h40, 32'h0, 0);
      apb(1, 8'h5C, 32'h0, 0);
      for (int k = 0; k < 4; k++)
      begin
         rnd = lfsr(rnd);
         list_marker <= rnd[1:0];
         sample();
         chk({s1[31], s0[31]}, rnd[1:0]);
      end
      chk(restarts, 2);
      apb(1, 8'h3C, 32'd100, 0);
      apb(1, 8'h3C, 32'd5, 0);
      repeat (3) @(posedge pclk);
      chk(restarts, 4);
      apb(1, `MSCG_A_CTRL, 32'h10, 0);
      apb(1, 8'h3C, 32'd100, 0);
      apb(0, 8'h3C, 0, {2'b10, 32'h3F});
      repeat (3) @(posedge pclk);
      chk(restarts, 4);
      apb(1, `MSCG_A_CTRL, 32'h1, 0);
      tp(n);
      chk(n, 20);
      apb(1, `MSCG_A_MULT, 32'h3, 0);
      apb(1, `MSCG_A_CTRL, 32'h3, 0);
      tp(n);
      chk(n, 60);
      apb(1, `MSCG_A_CTRL, 32'h5, 0);
      tp(n);
      chk(n, 40);
      apb(1, `MSCG_A_CTRL, 32'h9, 0);
      tp(n);
      chk(n, 20);
      repeat (200) @(posedge pclk);
      apb(0, `MSCG_A_FREQ, 0, 34'h0);
      @(posedge pclk);
      chk(rd >= 3 && rd <= 4, 1);
      ext_data_sel <= 1'b1;
      apb(1, `MSCG_A_CTRL, 32'h3, 0);
      apb(0, `MSCG_A_CTRL, 0, {2'b10, 32'h1});
      tp(n);
      chk(n, 20);
      ext_data_sel <= 1'b0;
      conclude();
   end
endmodule
